// ### rtl/serial_flow_map.svh
// constants for the serial port flow-control block: timing, control bytes,
// error codes and power-on settings; included by the top.
// Functional notes
// - dtr forced on high, forced off low
// - gated dtr high unless receive buffer full
// - gated dtr mode: low dsr pauses transmitter
// - dtr mode change refused under rs422, -221
// - rts forced on high, forced off low
// - gated rts high unless receive buffer full
// - gated rts mode: low cts pauses transmitter
// - one baud setting shared by both directions
// - baud 50 to 115200 listed steps, default 9600
// - unsupported baud refused with -224, rate kept
// - one shared word length, 7 or 8
// - other word lengths refused with -224
// - pacing sends xon when ready, xoff when full
// - reset keeps all serial settings unchanged
// - dtr and rts modes read back
`ifndef SERIAL_FLOW_MAP_SVH
`define SERIAL_FLOW_MAP_SVH

`define SFC_CLK_HZ 100000000
`define SFC_FIFO_DEPTH 8
`define SFC_XON_BYTE 8'h11
`define SFC_XOFF_BYTE 8'h13
`define SFC_ERR_CONFLICT 16'hff23
`define SFC_ERR_ILLEGAL 16'hff20
`define SFC_BAUD_DEF_SEL 5'h0c
`define SFC_BAUD_COUNT 17
`define SFC_WORD8_VALUE 17'h00008
`define SFC_WORD7_VALUE 17'h00007

`endif

// ### rtl/serial_flow_pkg.sv
// types shared by the serial flow-control top, its checker and its bench.
// assumes it compiles before the modules that import it.
`default_nettype none
package serial_flow_pkg;
  typedef enum logic [1:0] {LINE_ON, LINE_OFF, LINE_GATED} line_mode_t;
  typedef enum logic [2:0] {ITEM_DTR, ITEM_RTS, ITEM_BAUD, ITEM_BITS, ITEM_SOFTWARE_PACING_SELECT} cfg_item_t;
  typedef enum logic {DIR_RX, DIR_TX} cfg_dir_t;
  typedef enum logic {TX_IDLE, TX_SHIFT} tx_state_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;

  typedef struct packed {
    line_mode_t dtr_mode;
    line_mode_t rts_mode;
    logic [4:0] baud_sel;
    logic bits8;
    logic software_pacing_select;
  } cfg_t;

  typedef struct packed {
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic [2:0] sync3;
    logic [2:0] filt;
    tx_state_t tx_st;
    logic [20:0] tx_cnt;
    logic [3:0] tx_bits;
    logic [9:0] tx_shift;
    rx_state_t rx_st;
    logic [20:0] rx_cnt;
    logic [3:0] rx_bits;
    logic [7:0] rx_shift;
    logic push_valid;
    logic [7:0] push_data;
    logic was_full;
    logic xon_pend;
    logic xoff_pend;
    logic dtr;
    logic rts;
    logic err_valid;
    logic [15:0] err_code;
  } flow_state_t;
endpackage : serial_flow_pkg
`default_nettype wire

// ### rtl/byte_fifo_if.sv
// handshake bundle between the receive path and its fifo.
// assumes both sides run on the same clock.
`default_nettype none
interface byte_fifo_if #(parameter int WIDTH = 8);
  logic [WIDTH-1:0] wr_data;
  logic wr_valid;
  logic wr_ready;
  logic [WIDTH-1:0] rd_data;
  logic rd_valid;
  logic rd_ready;
  modport fifo (input wr_data, input wr_valid, output wr_ready,
                output rd_data, output rd_valid, input rd_ready);
  modport user (output wr_data, output wr_valid, input wr_ready,
                input rd_data, input rd_valid, output rd_ready);
endinterface : byte_fifo_if
`default_nettype wire

// ### rtl/byte_fifo.sv
// synchronous fifo with valid/ready on both sides.
// assumes one clock and an asynchronous active-high reset.
`default_nettype none
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk, // system clock
  input wire logic rst, // async reset, active high
  byte_fifo_if.fifo q   // push and pop sides
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [AW:0] count;
  } fifo_state_t;

  fifo_state_t st_ff;
  fifo_state_t nxt_st;
  logic [WIDTH-1:0] mem [DEPTH];
  logic do_push;
  logic do_pop;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  assign q.wr_ready = (st_ff.count != (AW+1)'(DEPTH));
  assign q.rd_valid = (st_ff.count != '0);
  assign q.rd_data = mem[st_ff.rptr];
  assign do_push = q.wr_valid & q.wr_ready;
  assign do_pop = q.rd_valid & q.rd_ready;

  always_comb begin
    nxt_st = st_ff;
    if (do_push) begin
      nxt_st.wptr = bump(st_ff.wptr);
    end
    if (do_pop) begin
      nxt_st.rptr = bump(st_ff.rptr);
    end
    case ({do_push, do_pop})
      2'b10: nxt_st.count = st_ff.count + 1'b1;
      2'b01: nxt_st.count = st_ff.count - 1'b1;
      default: nxt_st.count = st_ff.count;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // storage needs no reset; the pointers and the count define what is valid
  always_ff @(posedge clk) begin
    if (do_push) begin
      mem[st_ff.wptr] <= q.wr_data;
    end
  end
endmodule // byte_fifo
`default_nettype wire

// ### rtl/serial_port_flow_control.sv
// serial port with shared settings, dtr/rts modem-line flow control and
// optional xon/xoff pacing; received bytes wait in an 8-word fifo.
// assumes rxd, dsr and cts arrive asynchronously from the link; the
// settings port and rs422_sel come from logic on clk.
`include "serial_flow_map.svh"
`default_nettype none
module serial_port_flow_control
  import serial_flow_pkg::*;
#(
  parameter int CLK_HZ = `SFC_CLK_HZ,
  parameter int FIFO_DEPTH = `SFC_FIFO_DEPTH
) (
  input wire logic clk,              // system clock
  input wire logic rst,              // async reset, active high
  input wire logic cfg_wr,           // one-cycle settings write strobe
  input wire cfg_item_t cfg_item,    // which setting is written
  input wire cfg_dir_t cfg_dir,      // receive or transmit control used
  input wire logic [16:0] cfg_value, // requested value
  input wire logic rs422_sel,        // rs422 interface selected
  output line_mode_t dtr_mode,       // current dtr mode
  output line_mode_t rts_mode,       // current rts mode
  output logic [16:0] baud_rate,     // current baud rate
  output logic [3:0] word_bits,      // current word length
  output logic software_pacing_select_en,              // xon/xoff pacing enabled
  output logic err_valid,            // one-cycle error pulse
  output logic [15:0] err_code,      // signed error code
  input wire logic [7:0] tx_data,    // byte to send
  input wire logic tx_valid,         // tx_data offered
  output logic tx_ready,             // byte taken this cycle
  output logic [7:0] rx_data,        // oldest received byte
  output logic rx_valid,             // rx_data holds a byte
  input wire logic rx_ready,         // consumer takes rx_data
  input wire logic rxd,              // serial input pin
  output logic txd,                  // serial output pin
  input wire logic dsr,              // far party ready, dtr pacing
  input wire logic cts,              // far party clear, rts pacing
  output logic dtr,                  // dtr line
  output logic rts                   // rts line
);
  localparam int TXD_I = 2;
  localparam int DSR_I = 1;
  localparam int CTS_I = 0;

  localparam cfg_t CFG_POWERON = '{
    dtr_mode: LINE_GATED,
    rts_mode: LINE_GATED,
    baud_sel: `SFC_BAUD_DEF_SEL,
    bits8: 1'b1,
    software_pacing_select: 1'b0
  };

  // the rate table, indexed by the stored selector
  function automatic logic [16:0] baud_of(input logic [4:0] sel);
    case (sel)
      5'h00: baud_of = 17'd50;
      5'h01: baud_of = 17'd75;
      5'h02: baud_of = 17'd110;
      5'h03: baud_of = 17'd150;
      5'h04: baud_of = 17'd300;
      5'h05: baud_of = 17'd1200;
      5'h06: baud_of = 17'd1800;
      5'h07: baud_of = 17'd2000;
      5'h08: baud_of = 17'd2400;
      5'h09: baud_of = 17'd3600;
      5'h0a: baud_of = 17'd4800;
      5'h0b: baud_of = 17'd7200;
      5'h0c: baud_of = 17'd9600;
      5'h0d: baud_of = 17'd19200;
      5'h0e: baud_of = 17'd38400;
      5'h0f: baud_of = 17'd57600;
      default: baud_of = 17'd115200;
    endcase
  endfunction

  // clocks per bit; the slowest rate needs the full 21 bits
  function automatic logic [20:0] bit_div(input logic [4:0] sel);
    bit_div = 21'(CLK_HZ / int'(baud_of(sel)));
  endfunction

  // bit period in clocks minus one
  function automatic logic [20:0] period_m1(input logic [4:0] sel);
    period_m1 = bit_div(sel) - 21'h000001;
  endfunction

  cfg_t cfg_ff = CFG_POWERON;
  cfg_t nxt_cfg;
  flow_state_t st_ff;
  flow_state_t nxt_st;
  logic rx_full;
  logic tx_hold;
  logic [4:0] req_sel;
  logic req_ok;
  logic [7:0] tx_byte;
  logic tx_go;

  byte_fifo_if #(.WIDTH(8)) rxq ();

  byte_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_rx_fifo (
    .clk(clk),
    .rst(rst),
    .q(rxq.fifo)
  );

  assign rxq.wr_valid = st_ff.push_valid;
  assign rxq.wr_data = st_ff.push_data;
  assign rxq.rd_ready = rx_ready;
  assign rx_data = rxq.rd_data;
  assign rx_valid = rxq.rd_valid;
  assign rx_full = ~rxq.wr_ready;

  // readback of the stored settings
  assign dtr_mode = cfg_ff.dtr_mode;
  assign rts_mode = cfg_ff.rts_mode;
  assign baud_rate = baud_of(cfg_ff.baud_sel);
  assign word_bits = cfg_ff.bits8 ? 4'h8 : 4'h7;
  assign software_pacing_select_en = cfg_ff.software_pacing_select;
  assign err_valid = st_ff.err_valid;
  assign err_code = st_ff.err_code;
  assign txd = st_ff.tx_shift[0];
  assign dtr = st_ff.dtr;
  assign rts = st_ff.rts;

  // requested rate to selector; zero asks for the default
  always_comb begin
    req_ok = 1'b0;
    req_sel = `SFC_BAUD_DEF_SEL;
    if (cfg_value == 17'h00000) begin
      req_ok = 1'b1;
    end else begin
      for (int i = 0; i < `SFC_BAUD_COUNT; i++) begin
        if (baud_of(5'(i)) == cfg_value) begin
          req_ok = 1'b1;
          req_sel = 5'(i);
        end
      end
    end
  end

  // a paused far party only stops data; pacing bytes still go out
  assign tx_hold = ((cfg_ff.dtr_mode == LINE_GATED) & ~st_ff.filt[DSR_I]) |
                   ((cfg_ff.rts_mode == LINE_GATED) & ~st_ff.filt[CTS_I]);
  assign tx_ready = (st_ff.tx_st == TX_IDLE) & ~st_ff.xon_pend & ~st_ff.xoff_pend & ~tx_hold;
  assign tx_go = (st_ff.tx_st == TX_IDLE) &
                 (st_ff.xon_pend | st_ff.xoff_pend | (tx_valid & ~tx_hold));
  assign tx_byte = st_ff.xoff_pend ? `SFC_XOFF_BYTE :
                   (st_ff.xon_pend ? `SFC_XON_BYTE : tx_data);

  always_comb begin
    nxt_st = st_ff;
    nxt_cfg = cfg_ff;
    nxt_st.err_valid = 1'b0;
    nxt_st.push_valid = 1'b0;

    // three-stage pin sampling; a level counts once stages two and three agree
    nxt_st.sync1 = {rxd, dsr, cts};
    nxt_st.sync2 = st_ff.sync1;
    nxt_st.sync3 = st_ff.sync2;
    for (int i = 0; i < 3; i++) begin
      if (st_ff.sync2[i] == st_ff.sync3[i]) begin
        nxt_st.filt[i] = st_ff.sync3[i];
      end
    end

    // settings writes; either direction's control reaches the one copy
    if (cfg_wr) begin
      case (cfg_item)
        ITEM_DTR: begin
          if (rs422_sel) begin
            nxt_st.err_valid = 1'b1;
            nxt_st.err_code = `SFC_ERR_CONFLICT;
          end else if (cfg_value > 17'h00002) begin
            nxt_st.err_valid = 1'b1;
            nxt_st.err_code = `SFC_ERR_ILLEGAL;
          end else begin
            nxt_cfg.dtr_mode = line_mode_t'(cfg_value[1:0]);
          end
        end
        ITEM_RTS: begin
          if (cfg_value > 17'h00002) begin
            nxt_st.err_valid = 1'b1;
            nxt_st.err_code = `SFC_ERR_ILLEGAL;
          end else begin
            nxt_cfg.rts_mode = line_mode_t'(cfg_value[1:0]);
          end
        end
        ITEM_BAUD: begin
          if (req_ok) begin
            nxt_cfg.baud_sel = req_sel;
          end else begin
            nxt_st.err_valid = 1'b1;
            nxt_st.err_code = `SFC_ERR_ILLEGAL;
          end
        end
        ITEM_BITS: begin
          if (cfg_value == `SFC_WORD8_VALUE) begin
            nxt_cfg.bits8 = 1'b1;
          end else if (cfg_value == `SFC_WORD7_VALUE) begin
            nxt_cfg.bits8 = 1'b0;
          end else begin
            nxt_st.err_valid = 1'b1;
            nxt_st.err_code = `SFC_ERR_ILLEGAL;
          end
        end
        ITEM_SOFTWARE_PACING_SELECT: begin
          if (cfg_value > 17'h00001) begin
            nxt_st.err_valid = 1'b1;
            nxt_st.err_code = `SFC_ERR_ILLEGAL;
          end else begin
            nxt_cfg.software_pacing_select = cfg_value[0];
          end
        end
        default: begin
          nxt_st.err_valid = 1'b1;
          nxt_st.err_code = `SFC_ERR_ILLEGAL;
        end
      endcase
    end

    // modem lines follow their mode; gated means "fifo has room"
    case (cfg_ff.dtr_mode)
      LINE_ON: nxt_st.dtr = 1'b1;
      LINE_OFF: nxt_st.dtr = 1'b0;
      default: nxt_st.dtr = ~rx_full;
    endcase
    case (cfg_ff.rts_mode)
      LINE_ON: nxt_st.rts = 1'b1;
      LINE_OFF: nxt_st.rts = 1'b0;
      default: nxt_st.rts = ~rx_full;
    endcase

    // pacing: sending a byte clears its request, an edge of fullness
    // in the same cycle sets it again, so no edge is lost
    nxt_st.was_full = rx_full;
    if (tx_go & st_ff.xoff_pend) begin
      nxt_st.xoff_pend = 1'b0;
    end else if (tx_go & st_ff.xon_pend) begin
      nxt_st.xon_pend = 1'b0;
    end
    if (!cfg_ff.software_pacing_select) begin
      nxt_st.xon_pend = 1'b0;
      nxt_st.xoff_pend = 1'b0;
    end else if (rx_full & ~st_ff.was_full) begin
      nxt_st.xoff_pend = 1'b1;
      nxt_st.xon_pend = 1'b0;
    end else if (~rx_full & st_ff.was_full) begin
      nxt_st.xon_pend = 1'b1;
      nxt_st.xoff_pend = 1'b0;
    end

    // transmitter: start bit, data lsb first, one stop bit
    case (st_ff.tx_st)
      TX_IDLE: begin
        nxt_st.tx_shift = 10'h3ff;
        if (tx_go) begin
          nxt_st.tx_st = TX_SHIFT;
          nxt_st.tx_cnt = period_m1(cfg_ff.baud_sel);
          nxt_st.tx_shift = cfg_ff.bits8 ? {1'b1, tx_byte, 1'b0} :
                                          {2'b11, tx_byte[6:0], 1'b0};
          nxt_st.tx_bits = cfg_ff.bits8 ? 4'ha : 4'h9;
        end
      end
      TX_SHIFT: begin
        if (st_ff.tx_cnt == 21'h000000) begin
          nxt_st.tx_cnt = period_m1(cfg_ff.baud_sel);
          nxt_st.tx_shift = {1'b1, st_ff.tx_shift[9:1]};
          nxt_st.tx_bits = st_ff.tx_bits - 4'h1;
          if (st_ff.tx_bits == 4'h1) begin
            nxt_st.tx_st = TX_IDLE;
          end
        end else begin
          nxt_st.tx_cnt = st_ff.tx_cnt - 21'h000001;
        end
      end
      default: nxt_st.tx_st = TX_IDLE;
    endcase

    // receiver: sample each bit at its middle; a bad stop bit drops the byte
    case (st_ff.rx_st)
      RX_IDLE: begin
        if (!st_ff.filt[TXD_I]) begin
          nxt_st.rx_st = RX_START;
          nxt_st.rx_cnt = bit_div(cfg_ff.baud_sel) >> 1;
        end
      end
      RX_START: begin
        if (st_ff.rx_cnt == 21'h000000) begin
          nxt_st.rx_st = st_ff.filt[TXD_I] ? RX_IDLE : RX_DATA;
          nxt_st.rx_cnt = period_m1(cfg_ff.baud_sel);
          nxt_st.rx_bits = 4'h0;
        end else begin
          nxt_st.rx_cnt = st_ff.rx_cnt - 21'h000001;
        end
      end
      RX_DATA: begin
        if (st_ff.rx_cnt == 21'h000000) begin
          nxt_st.rx_cnt = period_m1(cfg_ff.baud_sel);
          nxt_st.rx_shift = {st_ff.filt[TXD_I], st_ff.rx_shift[7:1]};
          nxt_st.rx_bits = st_ff.rx_bits + 4'h1;
          if (st_ff.rx_bits == (cfg_ff.bits8 ? 4'h7 : 4'h6)) begin
            nxt_st.rx_st = RX_STOP;
          end
        end else begin
          nxt_st.rx_cnt = st_ff.rx_cnt - 21'h000001;
        end
      end
      RX_STOP: begin
        if (st_ff.rx_cnt == 21'h000000) begin
          nxt_st.rx_st = RX_IDLE;
          // a byte arriving into a full fifo is lost; gating should prevent it
          nxt_st.push_valid = st_ff.filt[TXD_I];
          nxt_st.push_data = cfg_ff.bits8 ? st_ff.rx_shift : {1'b0, st_ff.rx_shift[7:1]};
        end else begin
          nxt_st.rx_cnt = st_ff.rx_cnt - 21'h000001;
        end
      end
      default: nxt_st.rx_st = RX_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_ff <= '{
        tx_st: TX_IDLE,
        rx_st: RX_IDLE,
        tx_shift: 10'h3ff,
        sync1: 3'h7,
        sync2: 3'h7,
        sync3: 3'h7,
        filt: 3'h7,
        default: '0
      };
    end else begin
      st_ff <= nxt_st;
    end
  end

  // settings live outside the reset so a reset leaves them as configured
  always_ff @(posedge clk) begin
    cfg_ff <= nxt_cfg;
  end

  logic unused_dir;
  assign unused_dir = cfg_dir;
endmodule // serial_port_flow_control
`default_nettype wire

// ### dv/sfc_ref_pkg.sv
// reference values for the serial flow-control bench: the legal baud list.
// assumes nothing beyond a plain compile before its users.
`default_nettype none
package sfc_ref_pkg;
  localparam logic [16:0] BAUDS [17] = '{17'h00032, 17'h0004b, 17'h0006e, 17'h00096,
    17'h0012c, 17'h004b0, 17'h00708, 17'h007d0, 17'h00960, 17'h00e10, 17'h012c0,
    17'h01c20, 17'h02580, 17'h04b00, 17'h09600, 17'h0e100, 17'h1c200};
  // zero asks for the default rate, so it counts as legal
  function automatic logic legal_baud(input logic [16:0] val);
    foreach (BAUDS[i]) if (BAUDS[i] == val) return 1'b1;
    return val == 17'h00000;
  endfunction
endpackage : sfc_ref_pkg
`default_nettype wire

// ### dv/host_term.sv
// host terminal model on the far side of the serial link.
// assumes bit_cyc and bits8 match the device settings during a frame.
`default_nettype none
module host_term (
  input wire logic clk, // system clock
  input wire logic txd, // device serial output
  input wire logic [7:0] bit_cyc, // clocks per bit
  input wire logic bits8, // eight data bits
  output logic rxd, // line into the device, idles at mark
  output logic dsr, // ready towards the device
  output logic cts // clear towards the device
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] got_q[$];
  logic [7:0] sh;
  initial begin
    rxd = 1'b1;
    dsr = 1'b1;
    cts = 1'b1;
  end
  task automatic hold(input logic no_dsr, input logic no_cts);
    @(posedge clk);
    #1;
    dsr = !no_dsr;
    cts = !no_cts;
  endtask
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = bits8 ? {1'b1, b, 1'b0} : {2'b11, b[6:0], 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk);
      #1;
      rxd = f[i];
      repeat (bit_cyc - 1) @(posedge clk);
    end
  endtask
  // samples mid-bit, well away from the device's own txd updates
  initial forever begin
    @(negedge txd);
    repeat (bit_cyc / 2) @(posedge clk);
    if (txd == 1'b0) begin
      for (int i = 0; i < 8; i++) begin
        repeat (bit_cyc) @(posedge clk);
        sh[i] = txd;
      end
      got_q.push_back(bits8 ? sh : {1'b0, sh[6:0]});
    end
  end
endmodule // host_term
`default_nettype wire

// ### dv/serial_port_flow_control_chk.sv
// assertions on the serial flow-control top: modem lines, holds, settings.
// assumes it is bound to the top and sees only its ports.
`default_nettype none
module serial_port_flow_control_chk
  import serial_flow_pkg::*, sfc_ref_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic rst, // async reset
  input wire logic cfg_wr, // settings strobe
  input wire cfg_item_t cfg_item, // setting chosen
  input wire logic [16:0] cfg_value, // requested value
  input wire logic rs422_sel, // rs422 chosen
  input wire line_mode_t dtr_mode, // dtr mode
  input wire line_mode_t rts_mode, // rts mode
  input wire logic [16:0] baud_rate, // baud rate
  input wire logic [3:0] word_bits, // word length
  input wire logic software_pacing_select_en, // pacing on
  input wire logic err_valid, // error pulse
  input wire logic [15:0] err_code, // error code
  input wire logic tx_ready, // byte taken
  input wire logic txd, // serial out
  input wire logic dsr, // far ready
  input wire logic cts, // far clear
  input wire logic dtr, // dtr line
  input wire logic rts // rts line
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  dtr_force_a: assert property (
    dtr_mode != LINE_GATED |=> dtr == ($past(dtr_mode) == LINE_ON))
    else $error("dtr off its forced level");
  rts_force_a: assert property (
    rts_mode != LINE_GATED |=> rts == ($past(rts_mode) == LINE_ON))
    else $error("rts off its forced level");
  // six samples cover the three-flop sync plus the filter
  dsr_pause_a: assert property (
    (dtr_mode == LINE_GATED && !dsr) [*6] |-> !tx_ready)
    else $error("transmit taken while dsr low");
  cts_pause_a: assert property (
    (rts_mode == LINE_GATED && !cts) [*6] |-> !tx_ready)
    else $error("transmit taken while cts low");
  baud_refuse_a: assert property (
    cfg_wr && cfg_item == ITEM_BAUD && !legal_baud(cfg_value)
    |=> err_valid && err_code == 16'hff20 && $stable(baud_rate))
    else $error("bad baud not refused");
  dtr_refuse_a: assert property (
    cfg_wr && cfg_item == ITEM_DTR && rs422_sel
    |=> err_valid && err_code == 16'hff23 && $stable(dtr_mode))
    else $error("dtr change under rs422 not refused");
  bits_set_a: assert property (
    cfg_wr && cfg_item == ITEM_BITS && cfg_value inside {17'h00007, 17'h00008}
    |=> !err_valid && {13'h0000, word_bits} == $past(cfg_value))
    else $error("word length not taken");
  cfg_hold_a: assert property (
    !cfg_wr |=> $stable(baud_rate) && $stable(word_bits) && $stable(software_pacing_select_en)
    && $stable(dtr_mode) && $stable(rts_mode))
    else $error("setting moved without a write");
  cover property (dtr_mode == LINE_GATED && !dtr);
  cover property (err_valid && err_code == 16'hff23);
  cover property (software_pacing_select_en && !txd);
endmodule // serial_port_flow_control_chk
bind serial_port_flow_control serial_port_flow_control_chk chk_i (.clk, .rst, .cfg_wr,
  .cfg_item, .cfg_value, .rs422_sel, .dtr_mode, .rts_mode, .baud_rate, .word_bits,
  .software_pacing_select_en, .err_valid, .err_code, .tx_ready, .txd, .dsr, .cts, .dtr, .rts);
`default_nettype wire

// ### dv/serial_port_flow_control_tb_top.sv
// self-checking bench for the serial flow-control top with a host model.
// assumes design files, reference package, model and checker compile first.
`default_nettype none
module serial_port_flow_control_tb_top
  import serial_flow_pkg::*, sfc_ref_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int CLK_HZ = 1843200; // 115200 baud is 16 clocks, keeps frames short
  logic clk, rst, cfg_wr, rs422_sel, tx_valid, tx_ready, rx_valid, rx_ready, err_valid;
  logic software_pacing_select_en, txd, rxd, dsr, cts, dtr, rts, b8;
  cfg_item_t cfg_item;
  cfg_dir_t cfg_dir;
  line_mode_t dtr_mode, rts_mode;
  logic [16:0] cfg_value, baud_rate, v;
  logic [15:0] err_code;
  logic [7:0] tx_data, rx_data, bc, d;
  logic [3:0] word_bits;
  logic [31:0] seed = 32'h00011846;
  logic [7:0] exp_q[$];
  int err_total, samples_checked, cyc;
  serial_port_flow_control #(.CLK_HZ(CLK_HZ)) serial_port_flow_control_i (.clk, .rst,
    .cfg_wr, .cfg_item, .cfg_dir, .cfg_value, .rs422_sel, .dtr_mode, .rts_mode,
    .baud_rate, .word_bits, .software_pacing_select_en, .err_valid, .err_code, .tx_data, .tx_valid,
    .tx_ready, .rx_data, .rx_valid, .rx_ready, .rxd, .txd, .dsr, .cts, .dtr, .rts);
  host_term host_term_i (.clk, .txd, .bit_cyc(bc), .bits8(b8), .rxd, .dsr, .cts);
  task automatic conclude();
    if (err_total == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(cfg_item_t it, logic [16:0] val, logic e, logic [15:0] c);
    tick(1);
    cfg_wr = 1'b1;
    cfg_item = it;
    cfg_dir = cfg_dir_t'(1'(xs()));
    cfg_value = val;
    tick(1);
    cfg_wr = 1'b0;
    chk("err_valid", err_valid, e);
    if (e) chk("err_code", err_code, c);
  endtask
  task automatic send_tx(input logic [7:0] b);
    // let one edge pass with valid low between two offers
    tick(1);
    tx_data = b;
    tx_valid = 1'b1;
    while (tx_ready !== 1'b1) tick(1);
    tick(1);
    tx_valid = 1'b0;
  endtask
  task automatic got(input logic [7:0] e);
    chk("host byte", host_term_i.got_q.size() ? host_term_i.got_q.pop_front() : 9'h100, e);
  endtask
  task automatic drain();
    rx_ready = 1'b1;
    while (exp_q.size() != 0) begin
      chk("rx_valid", rx_valid, 1'b1);
      chk("rx_data", rx_data, exp_q.pop_front());
      tick(1);
    end
    rx_ready = 1'b0;
    chk("rx_valid", rx_valid, 1'b0);
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      err_total++;
      conclude();
    end
  end
  initial begin
    rst = 1'b1;
    cfg_wr = 1'b0;
    cfg_item = ITEM_DTR;
    cfg_dir = DIR_RX;
    cfg_value = '0;
    rs422_sel = 1'b0;
    tx_valid = 1'b0;
    tx_data = '0;
    rx_ready = 1'b0;
    bc = 8'hc0;
    b8 = 1'b1;
    repeat (10) @(posedge clk);
    #1 rst = 1'b0;
    foreach (BAUDS[i]) begin
      wr(ITEM_BAUD, BAUDS[i], 1'b0, 16'h0000);
      chk("baud_rate", baud_rate, BAUDS[i]);
    end
    wr(ITEM_BAUD, 17'h00000, 1'b0, 16'h0000);
    chk("baud_rate", baud_rate, 17'h02580);
    for (int i = 0; i < 8; i++) begin
      v = (i == 0) ? 17'h00031 : (i == 1) ? 17'h1c201 : 17'(xs());
      if (legal_baud(v)) v = 17'h0004c;
      wr(ITEM_BAUD, v, 1'b1, 16'hff20);
      chk("baud_rate", baud_rate, 17'h02580);
    end
    wr(ITEM_BITS, 17'h00007, 1'b0, 16'h0000);
    chk("word_bits", word_bits, 4'h7);
    for (int i = 0; i < 4; i++) begin
      v = (i == 0) ? 17'h00009 : 17'(xs() & 32'h6);
      wr(ITEM_BITS, v, 1'b1, 16'hff20);
      chk("word_bits", word_bits, 4'h7);
    end
    wr(ITEM_BITS, 17'h00008, 1'b0, 16'h0000);
    for (int m = 0; m < 3; m++) begin
      wr(ITEM_DTR, 17'(m), 1'b0, 16'h0000);
      wr(ITEM_RTS, 17'(m), 1'b0, 16'h0000);
      tick(1);
      chk("dtr_mode", dtr_mode, m);
      chk("rts_mode", rts_mode, m);
      chk("dtr", dtr, m != 1);
      chk("rts", rts, m != 1);
    end
    rs422_sel = 1'b1;
    wr(ITEM_DTR, 17'h00000, 1'b1, 16'hff23);
    chk("dtr_mode", dtr_mode, LINE_GATED);
    wr(ITEM_RTS, 17'h00001, 1'b0, 16'h0000);
    tick(1);
    chk("rts", rts, 1'b0);
    rs422_sel = 1'b0;
    wr(ITEM_DTR, 17'h00001, 1'b0, 16'h0000);
    wr(ITEM_SOFTWARE_PACING_SELECT, 17'h00001, 1'b0, 16'h0000);
    wr(ITEM_BAUD, 17'h1c200, 1'b0, 16'h0000);
    rst = 1'b1;
    tick(3);
    rst = 1'b0;
    tick(1);
    chk("baud_rate", baud_rate, 17'h1c200);
    chk("settings", {word_bits, software_pacing_select_en, dtr_mode, rts_mode}, {4'h8, 1'b1, LINE_OFF, LINE_OFF});
    chk("dtr", dtr, 1'b0);
    bc = 8'h10;
    wr(ITEM_DTR, 17'h00002, 1'b0, 16'h0000);
    wr(ITEM_RTS, 17'h00002, 1'b0, 16'h0000);
    for (int i = 0; i < 6; i++) begin
      if (i == 4) begin
        tick(200);
        wr(ITEM_BITS, 17'h00007, 1'b0, 16'h0000);
        b8 = 1'b0;
      end
      d = 8'(xs());
      exp_q.push_back(b8 ? d : {1'b0, d[6:0]});
      send_tx(d);
    end
    tick(200);
    while (exp_q.size() != 0) got(exp_q.pop_front());
    wr(ITEM_BITS, 17'h00008, 1'b0, 16'h0000);
    b8 = 1'b1;
    for (int k = 0; k < 2; k++) begin
      host_term_i.hold(k == 0, k == 1);
      tick(8);
      chk("tx_ready", tx_ready, 1'b0);
      d = 8'(xs());
      fork
        send_tx(d);
      join_none
      tick(300);
      chk("host count", host_term_i.got_q.size(), 0);
      host_term_i.hold(1'b0, 1'b0);
      tick(250);
      got(d);
    end
    // nine bytes into eight words: the last one must be dropped
    for (int i = 0; i < 9; i++) begin
      d = 8'(xs());
      if (i < 8) exp_q.push_back(d);
      host_term_i.send(d);
    end
    tick(200);
    chk("dtr", dtr, 1'b0);
    chk("rts", rts, 1'b0);
    got(8'h13);
    drain();
    tick(200);
    got(8'h11);
    chk("dtr", dtr, 1'b1);
    wr(ITEM_SOFTWARE_PACING_SELECT, 17'h00000, 1'b0, 16'h0000);
    // the last fill arrives in 7-bit frames so the short receive path runs too
    wr(ITEM_BITS, 17'h00007, 1'b0, 16'h0000);
    b8 = 1'b0;
    for (int i = 0; i < 8; i++) begin
      d = 8'(xs());
      exp_q.push_back({1'b0, d[6:0]});
      host_term_i.send(d);
    end
    tick(200);
    chk("host count", host_term_i.got_q.size(), 0);
    chk("rts", rts, 1'b0);
    drain();
    conclude();
  end
endmodule // serial_port_flow_control_tb_top
`default_nettype wire
